/* File: rtl/ebc_unit.sv */
// External bus control unit: sequencer, strobes, chip selects, hold
`timescale 1ns/1ps
// Overview of operation
// - Drive external bus only in expanded modes
// - 24 address lines, top line inverted
// - Per-area 8/16 width, area 3 strapped
// - Address held at reset value until first external access
// - DRAM row then column on A8-A20
// - Chip selects share upper lines, mode field
// - Microprocessor mode resets to area mode 0
// - Chip select falls with address
// - Next access decides address/select change
// - Idle after external keeps address and select
// - Bit 2 picks strobe set on 16-bit
// - Reset selects enable-style strobe set
// - Per-byte style: separate low/high writes
// - Enable style: byte enable with A0
// - Latch strobe for multiplexed, pin selectable
// - Ready sampled on bus clock falling edge
// - Ready honoured only during software wait
// - Ready state holds all bus outputs
// - Hold request grants bus after access
// - Priority hold, then DMA, then CPU
// - Hold floats strobes, address, data; selects driven high
// - Internal access keeps address and hbe_n, other strobes high
// - Clock output pin follows select bits
// - DRAM strobes only on DRAM accesses
// - Separate bus wait counts 0/1/1/2/3
// - Multiplexed bus at least two waits
module ebc_unit (
  input wire logic clock,
  input wire logic resetn,
  input wire ebc_pkg::ebc_cfg_s cfg,
  input wire logic bus_width_pin,
  input wire logic cpu_req_valid,
  input wire ebc_pkg::ebc_req_s cpu_req,
  output logic cpu_req_ready,
  input wire logic dma_req_valid,
  input wire ebc_pkg::ebc_req_s dma_req,
  output logic dma_req_ready,
  output logic [ebc_pkg::EBC_DW-1:0] rdata,
  output logic rdata_valid,
  output logic [ebc_pkg::EBC_AW-1:0] addr_out,
  output logic addr_oe,
  output logic [ebc_pkg::EBC_DW-1:0] data_out,
  output logic data_oe,
  input wire logic [ebc_pkg::EBC_DW-1:0] data_in,
  output logic [3:0] chip_select_n,
  output ebc_pkg::ebc_strb_s strobes,
  output logic strobe_oe,
  output logic addr_latch_strobe,
  output logic [1:0] ale_pin_sel_out,
  input wire logic ready_in_n,
  input wire logic bus_clock,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  output logic row_strobe_n,
  output logic low_column_strobe_n,
  output logic high_column_strobe_n,
  output logic dram_write_n,
  input wire logic fc_clk,
  input wire logic f8_clk,
  input wire logic f32_clk,
  output logic clock_output_pin,
  output logic watchdog_stop,
  output logic width16_area3
);
  import ebc_pkg::*;

  ebc_state_e state_q, state_d;
  logic [1:0] rdy_s_q, hold_s_q, bck_s_q, bck_sync_q;
  logic [1:0] rst_seen_q;
  logic strap_q;
  ebc_req_s cur_q;
  logic [2:0] wcnt_q;
  logic [EBC_AW-1:0] addr_q;
  logic [3:0] cs_n_q;
  ebc_strb_s strb_q;
  logic ale_q, col_q, rdy_q, sw_wait_q, grant_q;
  logic ras_n_q, low_column_strobe_n_n_q, high_column_strobe_n_n_q, dw_n_q;
  logic [EBC_DW-1:0] rdata_q;
  logic rvalid_q;

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_s_q <= 2'h3;
      hold_s_q <= 2'h3;
      bck_s_q <= 2'h0;
      bck_sync_q <= 2'h0;
    end else begin
      rdy_s_q <= {rdy_s_q[0], ready_in_n};
      hold_s_q <= {hold_s_q[0], bus_request_n};
      bck_s_q <= {bck_s_q[0], bus_clock};
      bck_sync_q <= {bck_sync_q[0], bck_s_q[1]};
    end
  end

  wire rdy_n_sync = rdy_s_q[1];
  wire hold_req = !hold_s_q[1];
  wire bck_fall = bck_sync_q[1] && !bck_s_q[1];
  wire expanded = (cfg.pmode != EBC_PM_SINGLE);

  // Strap caught after reset release, so no port feeds an async load
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_seen_q <= 2'h0;
      strap_q <= 1'b0;
    end else begin
      rst_seen_q <= {rst_seen_q[0], 1'b1};
      if (!rst_seen_q[1]) begin
        strap_q <= !bus_width_pin;
      end
    end
  end

  // Area 3 width: strap ORed with its own software bit
  wire [3:0] width16 = {strap_q | cfg.width16[3], cfg.width16[2:0]};
  assign width16_area3 = width16[3];

  // Request arbitration, external hold wins first
  wire dma_win = dma_req_valid;
  wire any_req = cpu_req_valid || dma_req_valid;
  ebc_req_s next_req;
  assign next_req = dma_win ? dma_req : cpu_req;
  wire start = (state_q == EBC_IDLE) && any_req && !hold_req;
  assign dma_req_ready = start && dma_win;
  assign cpu_req_ready = start && !dma_win;

  // Wait count: mux spaces at least two, separate zero-wait reads take none
  wire [1:0] nw = cfg.wait_cfg[{next_req.area, 1'b0} +: 2];
  wire nmux = cfg.mux_sel != 2'h0;
  wire [2:0] nw_ext = nmux ? ((nw > 2'h1) ? {1'b0, nw} : EBC_MUX_WAITS)
    : ((nw == EBC_WAIT_NONE) ? {2'h0, next_req.write} : {1'b0, nw});
  wire [2:0] nw_int = next_req.sfr ? 3'h1 : {2'h0, cfg.int_wait};
  wire [2:0] nwait = next_req.ext ? nw_ext : nw_int;
  wire nsw = next_req.ext && (nw != EBC_WAIT_NONE || nmux);

  // Chip select decode by area mode; area 2 is DRAM in modes 0-2
  wire dram_on = cfg.dram_ctl != 3'h0;
  wire [1:0] am = (cfg.pmode == EBC_PM_MICRO && !rst_seen_q[1]) ?
    EBC_AREA_MODE_RST : cfg.area_mode;
  wire is_dram = next_req.area == 2'h2 && dram_on && am != 2'h3;
  logic [3:0] cs_dec;
  always_comb begin
    cs_dec = EBC_CS_IDLE;
    if (am != EBC_AREA_MODE_RST) begin
      case (next_req.area)
        2'h0: cs_dec = 4'he;
        2'h1: cs_dec = (am == 2'h2) ? 4'hf : 4'hd;
        2'h2: cs_dec = (am == 2'h3) ? 4'h7 : 4'hf;
        default: cs_dec = 4'hb;
      endcase
    end
  end
  // Pins: cs[0] area 3, cs[1] area 0, cs[2] area 1, cs[3] area 2
  wire [3:0] cs_to_pin = {cs_dec[3], cs_dec[1], cs_dec[0], cs_dec[2]};

  // Strobe encodings for the starting access
  wire n16 = width16[next_req.area];
  wire use_byte = n16 && cfg.per_byte;
  ebc_strb_s strb_go;
  always_comb begin
    strb_go = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    strb_go.rd_n = next_req.write;
    strb_go.hbe_n = !(n16 && next_req.hi_byte);
    if (use_byte) begin
      strb_go.wrl_n = !(next_req.write && next_req.lo_byte);
      strb_go.wrh_n = !(next_req.write && next_req.hi_byte);
    end else begin
      strb_go.wr_n = !next_req.write;
    end
  end

  // Sequencer
  wire wdone = wcnt_q == 3'h0;
  always_comb begin
    state_d = state_q;
    case (state_q)
      EBC_IDLE: begin
        if (hold_req) begin
          state_d = EBC_HOLD;
        end else if (start) begin
          state_d = EBC_ADDR;
        end
      end
      EBC_ADDR: state_d = wdone ? EBC_END : EBC_WAIT;
      EBC_WAIT: begin
        if (rdy_q) begin
          state_d = EBC_RDY;
        end else if (wdone) begin
          state_d = EBC_END;
        end
      end
      EBC_RDY: state_d = rdy_q ? EBC_RDY : EBC_WAIT;
      EBC_END: state_d = EBC_IDLE;
      EBC_HOLD: state_d = hold_req ? EBC_HOLD : EBC_IDLE;
      default: state_d = EBC_IDLE;
    endcase
  end

  wire last_cycle = state_d == EBC_END && state_q != EBC_END;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= EBC_IDLE;
      grant_q <= 1'b0;
    end else begin
      state_q <= state_d;
      grant_q <= state_d == EBC_HOLD;
    end
  end

  // Ready: only inside software waits, sampled at bus clock fall
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_q <= 1'b0;
    end else if (!sw_wait_q || state_q == EBC_IDLE) begin
      rdy_q <= 1'b0;
    end else if (bck_fall && state_q != EBC_ADDR) begin
      rdy_q <= !rdy_n_sync;
    end
  end

  // Access bookkeeping and wait counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cur_q <= '0;
      wcnt_q <= 3'h0;
      sw_wait_q <= 1'b0;
      col_q <= 1'b0;
    end else if (start) begin
      cur_q <= next_req;
      wcnt_q <= nwait;
      sw_wait_q <= nsw;
      col_q <= 1'b0;
    end else if ((state_q == EBC_ADDR || state_q == EBC_WAIT) &&
                 !rdy_q && !wdone) begin
      wcnt_q <= wcnt_q - 3'h1;
      col_q <= 1'b1; // Column phase after the first cycle
    end
  end

  // Address and select: internal keeps address, select goes high
  // Idle keeps both, so a select may span several cycles
  wire [EBC_AW-1:0] col_addr = {cur_q.addr[EBC_AW-1:EBC_RAS_HI+1],
    cur_q.addr[EBC_RAS_W-1:0], cur_q.addr[EBC_RAS_LO-1:0]};
  wire dram_cur = cur_q.ext && cur_q.area == 2'h2 && dram_on &&
    am != 2'h3;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_q <= '0; // Held until the first external access
      cs_n_q <= EBC_CS_IDLE;
      strb_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    end else if (start) begin
      if (next_req.ext) begin
        addr_q <= next_req.addr;
        cs_n_q <= cs_to_pin;
        strb_q <= strb_go;
      end else begin
        cs_n_q <= EBC_CS_IDLE;
        strb_q <= '{1'b1, 1'b1, strb_q.hbe_n, 1'b1, 1'b1};
      end
    end else if (dram_cur && col_q && state_q == EBC_WAIT) begin
      addr_q <= col_addr;
    end else if (state_q == EBC_END) begin
      strb_q <= '{1'b1, 1'b1, strb_q.hbe_n, 1'b1, 1'b1};
    end
  end

  // DRAM strobes and latch strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ras_n_q <= 1'b1;
      low_column_strobe_n_n_q <= 1'b1;
      high_column_strobe_n_n_q <= 1'b1;
      dw_n_q <= 1'b1;
      ale_q <= 1'b0;
    end else begin
      ale_q <= start && nmux;
      ras_n_q <= !(dram_cur && state_q != EBC_IDLE &&
        state_q != EBC_HOLD);
      low_column_strobe_n_n_q <= !(dram_cur && col_q && cur_q.lo_byte);
      high_column_strobe_n_n_q <= !(dram_cur && col_q && cur_q.hi_byte);
      dw_n_q <= !(dram_cur && cur_q.write);
    end
  end

  // Read capture at end of a read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= last_cycle && !cur_q.write;
      if (last_cycle && !cur_q.write) begin
        rdata_q <= data_in;
      end
    end
  end

  wire drive = expanded && !grant_q;
  wire dram_strb = dram_cur && state_q != EBC_IDLE;
  assign addr_out = {~addr_q[EBC_AW-1], addr_q[EBC_AW-2:0]};
  assign addr_oe = drive;
  assign data_out = cur_q.wdata;
  assign data_oe = drive && cur_q.ext && cur_q.write &&
    state_q != EBC_IDLE;
  assign chip_select_n = drive ? cs_n_q : EBC_CS_IDLE;
  assign strobes = (dram_strb || !drive) ?
    '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1} : strb_q;
  assign strobe_oe = drive;
  assign addr_latch_strobe = ale_q && expanded;
  assign ale_pin_sel_out = cfg.ale_pin_sel;
  assign bus_grant_n = !grant_q;
  assign watchdog_stop = grant_q;
  assign row_strobe_n = ras_n_q;
  assign low_column_strobe_n = low_column_strobe_n_n_q;
  assign high_column_strobe_n = high_column_strobe_n_n_q;
  assign dram_write_n = dw_n_q;
  assign rdata = rdata_q;
  assign rdata_valid = rvalid_q;

  // Clock output selection; bus clock source blocked in single chip unless clk_pin_sel is set
  logic clk_sel;
  always_comb begin
    case (cfg.clk_src_sel)
      2'h1: clk_sel = fc_clk;
      2'h2: clk_sel = f8_clk;
      2'h3: clk_sel = f32_clk;
      default: clk_sel = bck_sync_q[1];
    endcase
  end
  assign clock_output_pin = (!cfg.clk_pin_sel &&
    cfg.clk_src_sel == EBC_CLKSRC_BUS) ? (expanded && bck_sync_q[1]) :
    (cfg.clk_pin_sel ? clk_sel : 1'b0);

  // Grant only when the sequencer is parked in hold
  chk_grant_hold: assert property (@(posedge clock) disable iff (!resetn)
    !bus_grant_n |-> state_q == EBC_HOLD)
    else $error("grant without hold");
  chk_hold_float: assert property (@(posedge clock) disable iff (!resetn)
    !bus_grant_n |-> !addr_oe && !strobe_oe && chip_select_n == 4'hf)
    else $error("bus driven in hold");
  chk_single_off: assert property (@(posedge clock) disable iff (!resetn)
    cfg.pmode == EBC_PM_SINGLE |-> !addr_oe && !data_oe)
    else $error("bus driven in single chip");
  chk_ready_ign: assert property (@(posedge clock) disable iff (!resetn)
    !sw_wait_q |=> !rdy_q)
    else $error("ready taken without wait");
  chk_ready_hold: assert property (@(posedge clock) disable iff (!resetn)
    state_q == EBC_RDY && $past(state_q) == EBC_RDY |->
    $stable(addr_q) && $stable(strb_q))
    else $error("outputs moved in ready");
  chk_prio_dma: assert property (@(posedge clock) disable iff (!resetn)
    cpu_req_ready |-> !dma_req_valid && !hold_req)
    else $error("priority broken");
  chk_idle_keep: assert property (@(posedge clock) disable iff (!resetn)
    state_q == EBC_IDLE && !start && !hold_req ##1 state_q == EBC_IDLE
    |-> $stable(addr_q) && $stable(cs_n_q))
    else $error("idle changed address or select");
  sequence s_rel;
    hold_req ##1 !hold_req;
  endsequence
  chk_grant_release: assert property (@(posedge clock)
    disable iff (!resetn)
    state_q == EBC_HOLD ##0 s_rel |-> ##[1:2] bus_grant_n)
    else $error("grant not released");
  chk_msb_inv: assert property (@(posedge clock) disable iff (!resetn)
    addr_out[EBC_AW-1] != addr_q[EBC_AW-1])
    else $error("top address line not inverted");
endmodule

/* File: rtl/ebc_pkg.sv */
// Package for the external bus control unit: types and constants
package ebc_pkg;
  localparam int unsigned EBC_CLK_HZ = 20000000;
  localparam int unsigned EBC_AW = 24;
  localparam int unsigned EBC_DW = 16;
  localparam int unsigned EBC_RAS_LO = 8;
  localparam int unsigned EBC_RAS_HI = 20;
  localparam int unsigned EBC_RAS_W = EBC_RAS_HI - EBC_RAS_LO + 1;
  localparam logic [1:0] EBC_AREA_MODE_RST = 2'h0;
  localparam logic [1:0] EBC_WAIT_NONE = 2'h0;
  localparam logic [2:0] EBC_MUX_WAITS = 3'h2;
  localparam logic [1:0] EBC_CLKSRC_BUS = 2'h0;
  localparam logic [3:0] EBC_CS_IDLE = 4'hf;

  // Processor modes
  typedef enum logic [1:0] {
    EBC_PM_SINGLE = 2'h0,
    EBC_PM_EXPAND = 2'h1,
    EBC_PM_MICRO = 2'h2
  } ebc_pmode_e;

  // Bus sequencer states, Gray along idle-addr-wait-ready-end
  typedef enum logic [2:0] {
    EBC_IDLE = 3'h0,
    EBC_ADDR = 3'h1,
    EBC_WAIT = 3'h3,
    EBC_RDY = 3'h2,
    EBC_END = 3'h6,
    EBC_HOLD = 3'h4
  } ebc_state_e;

  // One access request
  typedef struct packed {
    logic ext;
    logic sfr;
    logic write;
    logic [EBC_AW-1:0] addr;
    logic [EBC_DW-1:0] wdata;
    logic lo_byte;
    logic hi_byte;
    logic [1:0] area;
  } ebc_req_s;

  // Static configuration bits
  typedef struct packed {
    ebc_pmode_e pmode;
    logic [1:0] area_mode;
    logic [3:0] width16;
    logic per_byte;
    logic [1:0] mux_sel;
    logic [1:0] ale_pin_sel;
    logic [7:0] wait_cfg;
    logic int_wait;
    logic [2:0] dram_ctl;
    logic clk_pin_sel;
    logic [1:0] clk_src_sel;
  } ebc_cfg_s;

  // Strobe group
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic hbe_n;
    logic wrl_n;
    logic wrh_n;
  } ebc_strb_s;
endpackage

/* File: verification/ebc_mem_model.sv */
// Behavioural external memory on the far side of the bus
`timescale 1ns/1ps
module ebc_mem_model (
  input wire logic clock,
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_out,
  input wire ebc_pkg::ebc_strb_s strobes,
  input wire logic strobe_oe,
  input wire logic slow,
  output logic [15:0] data_in,
  output logic ready_in_n
);
  import ebc_pkg::*;
  logic [15:0] mem [0:255];
  logic [15:0] last_q = 16'h5a5a;
  logic [3:0] stall_q = 4'hf;
  wire [7:0] idx = addr_out[8:1];
  wire rd = strobe_oe && !strobes.rd_n;
  wire lo_wr = strobe_oe && ((!strobes.wr_n && !addr_out[0]) ||
    !strobes.wrl_n);
  wire hi_wr = strobe_oe && ((!strobes.wr_n && !strobes.hbe_n) ||
    !strobes.wrh_n);
  // Released bus shows the inverse, so a stale value never matches
  assign data_in = rd ? mem[idx] : ~last_q;
  // Slow device stretches reads until the stall count runs out
  assign ready_in_n = !(slow && rd && stall_q != 4'h0);
  always_ff @(posedge clock) begin
    if (lo_wr) mem[idx][7:0] <= data_out[7:0];
    if (hi_wr) mem[idx][15:8] <= data_out[15:8];
    if (rd) last_q <= mem[idx];
    stall_q <= rd ? stall_q - {3'h0, stall_q != 4'h0} : 4'hf;
  end
endmodule

/* File: verification/tb_external_bus_control_unit.sv */
// Self-checking bench for the external bus control unit
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_external_bus_control_unit;
  import ebc_pkg::*;
  logic clock, resetn, bus_width_pin, cpu_req_valid, dma_req_valid;
  logic bus_clock, bus_request_n, slow, cpu_req_ready, dma_req_ready;
  logic rdata_valid, addr_oe, data_oe, strobe_oe, ready_in_n;
  logic bus_grant_n, watchdog_stop, width16_area3;
  ebc_cfg_s cfg;
  ebc_req_s cpu_req, dma_req;
  ebc_strb_s strobes;
  logic [15:0] rdata, data_out, data_in, wd;
  logic [23:0] addr_out, a, last_ad;
  logic [3:0] chip_select_n, last_cs;
  logic [7:0] base;
  logic [15:0] ref_mem [0:255];
  int mismatches, comparisons, seed, n;
  ebc_unit dut (.clock, .resetn, .cfg, .bus_width_pin, .cpu_req_valid,
    .cpu_req, .cpu_req_ready, .dma_req_valid, .dma_req, .dma_req_ready,
    .rdata, .rdata_valid, .addr_out, .addr_oe, .data_out, .data_oe,
    .data_in, .chip_select_n, .strobes, .strobe_oe, .addr_latch_strobe(),
    .ale_pin_sel_out(), .ready_in_n, .bus_clock, .bus_request_n,
    .bus_grant_n, .row_strobe_n(), .low_column_strobe_n(),
    .high_column_strobe_n(), .dram_write_n(), .fc_clk(1'b0),
    .f8_clk(1'b0), .f32_clk(1'b0), .clock_output_pin(), .watchdog_stop,
    .width16_area3);
  ebc_mem_model mem (.clock, .addr_out, .data_out, .strobes, .strobe_oe,
    .slow, .data_in, .ready_in_n);
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Flags are {dma, write, sfr}; bytes are {hi, lo}
  task automatic access(input logic [2:0] fl, input logic [23:0] ad,
      input logic [1:0] ar, input logic [1:0] by, input logic [15:0] d);
    ebc_req_s r;
    ebc_strb_s st, ex, m;
    logic [15:0] bm;
    logic seen;
    int k;
    r = '{ext: !fl[0], sfr: fl[0], write: fl[1], addr: ad, wdata: d,
      lo_byte: by[0], hi_byte: by[1], area: ar};
    seen = 1'b0;
    k = 0;
    st = '1;
    @(posedge clock);
    if (fl[2]) begin
      dma_req <= r;
      dma_req_valid <= 1'b1;
      cpu_req <= r;
      cpu_req_valid <= 1'b1;
    end else begin
      cpu_req <= r;
      cpu_req_valid <= 1'b1;
    end
    do begin
      @(negedge clock);
      k++;
    end while ((fl[2] ? dma_req_ready : cpu_req_ready) !== 1'b1 && k < 99);
    if (fl[2]) `CHK(cpu_req_ready, 1'b0)
    @(posedge clock);
    if (fl[2]) dma_req_valid <= 1'b0;
    else cpu_req_valid <= 1'b0;
    while (k < 299) begin
      @(negedge clock);
      k++;
      if (!seen && !(strobes.rd_n && strobes.wr_n && strobes.wrl_n &&
          strobes.wrh_n)) begin
        seen = 1'b1;
        st = strobes;
        last_ad = addr_out;
        last_cs = chip_select_n;
      end
      if (fl[1] ? seen && strobes.wr_n && strobes.wrl_n && strobes.wrh_n
          : rdata_valid === 1'b1) break;
    end
    if (k >= 299) mismatches++;
    m = cfg.per_byte ? 5'h04 : 5'h00;
    ex = cfg.per_byte ? {fl[1], 2'h2, !(fl[1] && by[0]), !(fl[1] && by[1])}
      : {fl[1], !fl[1], !by[1], 2'h3};
    bm = {{8{!by[1]}}, {8{!by[0]}}};
    if (!fl[0]) begin
      `CHK(last_ad, {~ad[23], ad[22:0]})
      `CHK(last_cs, ~(4'h1 << (ar + 2'h1)))
      `CHK(st | m, ex | m)
    end
    if (fl[1]) begin
      if (by[0]) ref_mem[ad[8:1]][7:0] = d[7:0];
      if (by[1]) ref_mem[ad[8:1]][15:8] = d[15:8];
    end else if (!fl[0]) `CHK(rdata | bm, ref_mem[ad[8:1]] | bm)
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Bus clock unrelated in phase to the system clock
  initial begin
    bus_clock = 1'b0;
    #13;
    forever #200 bus_clock = ~bus_clock;
  end
  initial begin
    #3000000;
    mismatches++;
    test_done;
  end
  initial begin
    seed = 32'h9e1e;
    resetn = 1'b0;
    {bus_width_pin, cpu_req_valid, dma_req_valid, slow} = 4'h0;
    bus_request_n = 1'b1;
    cpu_req = '0;
    dma_req = '0;
    cfg = '0;
    cfg.pmode = EBC_PM_MICRO;
    cfg.width16 = 4'hf;
    cfg.area_mode = 2'h3;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(bus_grant_n, 1'b1)
    `CHK(width16_area3, 1'b1)
    // Both strobe styles, with full, low and high byte traffic
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      cfg.per_byte <= s[0];
      a = {8'h10, 7'h0, 8'($random(seed)), 1'b0};
      wd = 16'($random(seed));
      access(3'b010, a, 2'h0, 2'h3, wd);
      access(3'b010, a, 2'h0, 2'h1, ~wd);
      access(3'b010, a | 24'h1, 2'h0, 2'h2, wd ^ 16'h5a5a);
      access(3'b000, a, 2'h0, 2'h3, 16'h0);
      access(3'b000, a | 24'h1, 2'h0, 2'h2, 16'h0);
    end
    repeat (4) @(negedge clock);
    `CHK({addr_out, chip_select_n}, {last_ad, last_cs})
    for (int k = 0; k < 4; k++) begin
      base = k == 3 ? 8'he0 : 8'h10 << k;
      a = {base, 8'h0, 7'($random(seed)), 1'b0};
      wd = 16'($random(seed));
      access(3'b010, a, 2'(k), 2'h3, wd);
      access(3'b000, a, 2'(k), 2'h3, 16'h0);
    end
    access(3'b001, 24'h000400, 2'h0, 2'h3, 16'h0);
    `CHK({addr_out, chip_select_n, strobes.rd_n}, {last_ad, 5'h1f})
    @(posedge clock);
    slow <= 1'b1;
    access(3'b000, a, 2'h3, 2'h3, 16'h0);
    @(posedge clock);
    cfg.wait_cfg <= 8'h40;
    access(3'b000, a, 2'h3, 2'h3, 16'h0);
    @(posedge clock);
    slow <= 1'b0;
    cfg.wait_cfg <= 8'h00;
    access(3'b110, a, 2'h3, 2'h3, ~wd);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (cpu_req_ready !== 1'b1 && n < 99);
    @(posedge clock);
    cpu_req_valid <= 1'b0;
    @(posedge clock);
    bus_request_n <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (bus_grant_n !== 1'b0 && n < 40);
    @(posedge clock);
    cpu_req_valid <= 1'b1;
    repeat (2) @(negedge clock);
    `CHK({bus_grant_n, addr_oe, data_oe, strobe_oe}, 4'h0)
    `CHK({cpu_req_ready, watchdog_stop}, 2'h1)
    @(posedge clock);
    bus_request_n <= 1'b1;
    cpu_req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (bus_grant_n !== 1'b1 && n < 40);
    `CHK(bus_grant_n, 1'b1)
    access(3'b000, a, 2'h3, 2'h3, 16'h0);
    @(posedge clock);
    cfg.pmode <= EBC_PM_SINGLE;
    repeat (3) @(negedge clock);
    `CHK({addr_oe, strobe_oe}, 2'h0)
    test_done;
  end
endmodule
